// ===== logic/cwg_avg.sv
`timescale 1ns/1ps
module cwg_avg #(
   parameter int W = 8,
   parameter int LOG2N = 4
) (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic sample,
   input wire logic [W-1:0] din,
   output logic [W-1:0] avg
);
   logic [W+LOG2N-1:0] acc;
   logic [LOG2N-1:0] cnt;
   logic [W+LOG2N-1:0] next_acc;

   generate
      if (W < 1 || LOG2N < 1 || LOG2N > 8) begin : g_bad
         $error("cwg_avg: unsupported width or window");
      end
   endgenerate

   assign next_acc = acc + (W+LOG2N)'(din);

   // window of 2**LOG2N samples, mean loaded at window end
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         acc <= '0;
         cnt <= '0;
         avg <= '0;
      end else if (sample) begin
         cnt <= cnt + 1'b1;
         if (&cnt) begin
            acc <= '0;
            avg <= next_acc[W+LOG2N-1:LOG2N];
         end else begin
            acc <= next_acc;
         end
      end
   end

   avg_window_a: assert property (@(posedge clk) disable iff (!arst_n)
      (sample && (&cnt)) |=> (avg == $past(next_acc[W+LOG2N-1:LOG2N]) && acc == '0))
      else $error("fuel mean not loaded at window end");
   avg_hold_a: assert property (@(posedge clk) disable iff (!arst_n)
      !(sample && (&cnt)) |=> $stable(avg))
      else $error("fuel mean changed inside window");
endmodule

// ===== logic/cwg_top.sv
// Operation
// - after ignition turns on with the driver buckle open, the buzzer sounds for 6 s, then stops.
// - at 20 km/h or more with either front belt open, the buzzer sounds for 93 s.
// - passenger belt is open only if its buckle is off and the seat sensor sees an occupant.
// - key reminder buzzer sounds with ignition in lock or accessory, key in, driver door open.
// - at ignition on the brake warning lamp lights for about 3 s as a bulb check.
// - parking brake or low brake fluid keeps the brake lamp lit past the bulb check.
// - the speedometer is driven from the vehicle speed received over the bus.
// - the tachometer is driven from the engine speed received over the bus.
// - the fuel gauge shows the fuel sender reading averaged over a fixed window.
// - the temperature gauge is driven from the coolant temperature received over the bus.
// - the oil pressure gauge is computed from coolant temperature and engine speed.
//
// Decided for this implementation: the register offsets and the AHB-Lite register port.
`timescale 1ns/1ps
`include "cwg_params.svh"
module cwg_top #(
   parameter int TICK_CYC = `CWG_TICK_CYC,
   parameter int FUEL_W = 8,
   parameter int FUEL_LOG2 = 4,
   parameter int OIL_BASE = 64,
   parameter int OIL_RPM_SHIFT = 5,
   parameter int OIL_ECT_SHIFT = 2
) (
   input wire logic CLK,
   input wire logic ARST_N,
   input wire logic HSEL,
   input wire logic [31:0] HADDR,
   input wire logic [1:0] HTRANS,
   input wire logic HWRITE,
   input wire logic [2:0] HSIZE,
   input wire logic [31:0] HWDATA,
   input wire logic HREADY,
   output logic [31:0] HRDATA,
   output logic HREADYOUT,
   output logic HRESP,
   input wire logic IGNITION_RUN_SUPPLY,
   input wire logic DRV_BUCKLE,
   input wire logic PASS_BUCKLE,
   input wire logic SEAT_OCCUPIED,
   input wire logic KEY_INSERTED,
   input wire logic DRV_DOOR_OPEN,
   input wire logic PARK_BRAKE,
   input wire logic BRAKE_FLUID_LOW,
   input wire logic [FUEL_W-1:0] FUEL_SENDER,
   input wire logic CAN_VALID,
   input wire cwg_pkg::cwg_can_t CAN_MSG,
   output logic BUZZER,
   output logic BRAKE_LAMP,
   output logic [15:0] SPEEDO,
   output logic [15:0] TACHO,
   output logic [15:0] TEMP_GAUGE,
   output logic [FUEL_W-1:0] FUEL_GAUGE,
   output logic [7:0] OIL_GAUGE
);
   localparam int TICK_MS = `CWG_TICK_US / 1000;
   localparam int START_TICKS = `CWG_BELT_START_MS / TICK_MS;
   localparam int RUN_TICKS = `CWG_BELT_RUN_MS / TICK_MS;
   localparam int CHECK_TICKS = `CWG_LAMP_CHECK_MS / TICK_MS;
   localparam int TW = 10;

   generate
      if (TICK_CYC < 2 || FUEL_W < 1 || FUEL_W > 32 || RUN_TICKS >= 2**TW
          || FUEL_LOG2 < 1 || FUEL_LOG2 > 8) begin : g_bad
         $error("cwg_top: unsupported parameter values");
      end
   endgenerate

   ////////////////////////////////////////////////////////////////////////////////
   // time base
   logic [31:0] tick_cnt;
   logic tick;

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         tick_cnt <= '0;
         tick <= 1'b0;
      end else if (tick_cnt == 32'(TICK_CYC - 1)) begin
         tick_cnt <= '0;
         tick <= 1'b1;
      end else begin
         tick_cnt <= tick_cnt + 32'h1;
         tick <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // belt, key and lamp conditions
   logic ign_q;
   logic ign_on;
   logic drv_open;
   logic pass_open;
   logic run_cond;
   logic run_q;
   logic key_cond;
   logic [15:0] speed;
   logic [15:0] rpm;
   logic [15:0] ect;
   logic [1:0] ctrl;

   assign ign_on = IGNITION_RUN_SUPPLY && !ign_q;
   assign drv_open = !DRV_BUCKLE;
   assign pass_open = !PASS_BUCKLE && SEAT_OCCUPIED;
   assign run_cond = IGNITION_RUN_SUPPLY && (speed >= 16'(`CWG_BELT_SPEED_KMH))
                     && (drv_open || pass_open);
   assign key_cond = !IGNITION_RUN_SUPPLY && KEY_INSERTED && DRV_DOOR_OPEN;

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ign_q <= 1'b0;
         run_q <= 1'b0;
      end else begin
         ign_q <= IGNITION_RUN_SUPPLY;
         run_q <= run_cond;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // alarm and check timers, in ticks
   logic [TW-1:0] start_t;
   logic [TW-1:0] run_t;
   logic [TW-1:0] check_t;

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         start_t <= '0;
      end else if (ign_on && drv_open) begin
         start_t <= TW'(START_TICKS);
      end else if (!IGNITION_RUN_SUPPLY || !drv_open) begin
         start_t <= '0;
      end else if (tick && start_t != '0) begin
         start_t <= start_t - 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         run_t <= '0;
      end else if (run_cond && !run_q) begin
         run_t <= TW'(RUN_TICKS);
      end else if (!run_cond) begin
         run_t <= '0;
      end else if (tick && run_t != '0) begin
         run_t <= run_t - 1'b1;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         check_t <= '0;
      end else if (ign_on) begin
         check_t <= TW'(CHECK_TICKS);
      end else if (!IGNITION_RUN_SUPPLY) begin
         check_t <= '0;
      end else if (tick && check_t != '0) begin
         check_t <= check_t - 1'b1;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // buzzer and brake lamp
   logic next_buzzer;
   logic next_lamp;

   assign next_buzzer = ctrl[`CWG_CTRL_ALARM_BIT]
                        && (start_t != '0 || run_t != '0 || key_cond);
   assign next_lamp = IGNITION_RUN_SUPPLY
                      && (check_t != '0 || PARK_BRAKE || BRAKE_FLUID_LOW);

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         BUZZER <= 1'b0;
         BRAKE_LAMP <= 1'b0;
      end else begin
         BUZZER <= next_buzzer;
         BRAKE_LAMP <= next_lamp;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // values received from the engine controller
   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         speed <= '0;
         rpm <= '0;
         ect <= '0;
      end else if (CAN_VALID) begin
         case (CAN_MSG.kind)
            cwg_pkg::SIG_SPEED: speed <= CAN_MSG.value;
            cwg_pkg::SIG_RPM: rpm <= CAN_MSG.value;
            cwg_pkg::SIG_ECT: ect <= CAN_MSG.value;
            default: ;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // gauge drive
   logic [FUEL_W-1:0] fuel_avg;
   logic signed [17:0] oil_calc;
   logic [7:0] oil_val;

   cwg_avg #(
      .W(FUEL_W),
      .LOG2N(FUEL_LOG2)
   ) u_fuel (
      .clk(CLK),
      .arst_n(ARST_N),
      .sample(tick),
      .din(FUEL_SENDER),
      .avg(fuel_avg)
   );

   // oil: base plus engine speed term, less a temperature term
   assign oil_calc = 18'(OIL_BASE) + 18'(rpm >> OIL_RPM_SHIFT) - 18'(ect >> OIL_ECT_SHIFT);
   assign oil_val = (oil_calc < 0) ? 8'h00 : (oil_calc > 18'sd255) ? 8'hff : oil_calc[7:0];

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         SPEEDO <= '0;
         TACHO <= '0;
         TEMP_GAUGE <= '0;
         FUEL_GAUGE <= '0;
         OIL_GAUGE <= '0;
      end else if (!ctrl[`CWG_CTRL_GAUGE_BIT]) begin
         SPEEDO <= '0;
         TACHO <= '0;
         TEMP_GAUGE <= '0;
         FUEL_GAUGE <= '0;
         OIL_GAUGE <= '0;
      end else begin
         SPEEDO <= speed;
         TACHO <= rpm;
         TEMP_GAUGE <= ect;
         FUEL_GAUGE <= fuel_avg;
         OIL_GAUGE <= oil_val;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // AHB-Lite slave, zero wait states
   logic take;
   logic wr_pend;
   logic [7:0] wr_ofs;
   cwg_pkg::cwg_status_t status;
   logic [31:0] next_rdata;

   assign take = HSEL && HTRANS[1] && HREADY;
   assign status = '{ign_run: IGNITION_RUN_SUPPLY, key_alarm: key_cond,
                     run_alarm: run_t != '0, start_alarm: start_t != '0,
                     lamp_check: check_t != '0, brake_lamp: BRAKE_LAMP, buzzer: BUZZER};

   always_comb begin
      next_rdata = 32'h0;
      case (HADDR[7:0])
         `CWG_CTRL_OFS: next_rdata = 32'(ctrl);
         `CWG_STATUS_OFS: next_rdata = 32'(status);
         `CWG_SPEED_OFS: next_rdata = 32'(speed);
         `CWG_RPM_OFS: next_rdata = 32'(rpm);
         `CWG_ECT_OFS: next_rdata = 32'(ect);
         `CWG_FUEL_OFS: next_rdata = 32'(fuel_avg);
         `CWG_OIL_OFS: next_rdata = 32'(oil_val);
         default: next_rdata = 32'h0;
      endcase
      if (HADDR[31:8] != 24'h0) begin
         next_rdata = 32'h0;
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         wr_pend <= 1'b0;
         wr_ofs <= 8'h00;
         HRDATA <= 32'h0;
      end else begin
         wr_pend <= take && HWRITE && HSIZE == 3'h2 && HADDR[31:8] == 24'h0;
         if (take) begin
            wr_ofs <= HADDR[7:0];
         end
         if (take && !HWRITE) begin
            HRDATA <= next_rdata;
         end
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         ctrl <= `CWG_CTRL_RESET;
      end else if (wr_pend && wr_ofs == `CWG_CTRL_OFS) begin
         ctrl <= HWDATA[1:0];
      end
   end

   always_ff @(posedge CLK or negedge ARST_N) begin
      if (!ARST_N) begin
         HREADYOUT <= 1'b0;
         HRESP <= 1'b0;
      end else begin
         HREADYOUT <= 1'b1;
         HRESP <= 1'b0;
      end
   end

   ////////////////////////////////////////////////////////////////////////////////
   // checks
   sequence belt_start_s;
      ign_on && drv_open;
   endsequence
   sequence run_rise_s;
      run_cond && !run_q;
   endsequence
   sequence speed_rx_s;
      CAN_VALID && CAN_MSG.kind == cwg_pkg::SIG_SPEED && ctrl[`CWG_CTRL_GAUGE_BIT];
   endsequence

   belt_start_load_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      belt_start_s |=> start_t == TW'(START_TICKS))
      else $error("start alarm timer not loaded");
   belt_start_buzz_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      belt_start_s ##1 ctrl[`CWG_CTRL_ALARM_BIT] |=> BUZZER)
      else $error("buzzer silent after ignition with belt open");
   run_alarm_load_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      run_rise_s |=> run_t == TW'(RUN_TICKS))
      else $error("run alarm timer not loaded");
   run_alarm_stop_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      !run_cond |=> run_t == '0)
      else $error("run alarm kept after condition cleared");
   pass_open_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      (PASS_BUCKLE || !SEAT_OCCUPIED) && DRV_BUCKLE |-> !run_cond)
      else $error("passenger belt counted open wrongly");
   key_buzz_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      key_cond && ctrl[`CWG_CTRL_ALARM_BIT] |=> BUZZER)
      else $error("key reminder buzzer silent");
   lamp_check_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      ign_on |=> check_t == TW'(CHECK_TICKS) ##1 BRAKE_LAMP)
      else $error("bulb check lamp not lit");
   lamp_hold_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      IGNITION_RUN_SUPPLY && (PARK_BRAKE || BRAKE_FLUID_LOW) |=> BRAKE_LAMP)
      else $error("brake lamp off with brake fault");
   speedo_drive_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      speed_rx_s ##1 ctrl[`CWG_CTRL_GAUGE_BIT] |=> SPEEDO == $past(CAN_MSG.value, 2))
      else $error("speedometer not driven from received speed");
   oil_drive_a: assert property (@(posedge CLK) disable iff (!ARST_N)
      ctrl[`CWG_CTRL_GAUGE_BIT] |=> OIL_GAUGE == $past(oil_val))
      else $error("oil gauge not driven from computed value");
endmodule

// ===== shared/cwg_params.svh
`ifndef CWG_PARAMS_SVH
`define CWG_PARAMS_SVH
// clock and time base
`define CWG_CLK_MHZ 200
`define CWG_TICK_US 100000
`define CWG_TICK_CYC (`CWG_TICK_US * `CWG_CLK_MHZ)
// alarm and check times, belt alarm speed
`define CWG_BELT_START_MS 6000
`define CWG_BELT_RUN_MS 93000
`define CWG_LAMP_CHECK_MS 3000
`define CWG_BELT_SPEED_KMH 20
// register offsets
`define CWG_CTRL_OFS 8'h00
`define CWG_STATUS_OFS 8'h04
`define CWG_SPEED_OFS 8'h08
`define CWG_RPM_OFS 8'h0c
`define CWG_ECT_OFS 8'h10
`define CWG_FUEL_OFS 8'h14
`define CWG_OIL_OFS 8'h18
// control fields and reset value
`define CWG_CTRL_ALARM_BIT 0
`define CWG_CTRL_GAUGE_BIT 1
`define CWG_CTRL_RESET 2'h3
`endif

// ===== shared/cwg_pkg.sv
package cwg_pkg;
   typedef enum logic [1:0] {
      SIG_SPEED,
      SIG_RPM,
      SIG_ECT
   } cwg_sig_t;

   typedef struct packed {
      cwg_sig_t kind;
      logic [15:0] value;
   } cwg_can_t;

   typedef struct packed {
      logic ign_run;
      logic key_alarm;
      logic run_alarm;
      logic start_alarm;
      logic lamp_check;
      logic brake_lamp;
      logic buzzer;
   } cwg_status_t;
endpackage

// ===== sim/cwg_ecu_model.sv
`timescale 1ns/1ps
module cwg_ecu_model (
   input wire logic clk,
   input wire logic arst_n,
   input wire logic send,
   input wire cwg_pkg::cwg_sig_t kind,
   input wire logic [15:0] value,
   output logic can_valid,
   output cwg_pkg::cwg_can_t can_msg
);
   ////////////////////////////////////////////////////////////////
   // one message per request, payload scrambled between messages
   always_ff @(posedge clk or negedge arst_n) begin
      if (!arst_n) begin
         can_valid <= 1'b0;
         can_msg <= '0;
      end else if (send) begin
         can_valid <= 1'b1;
         can_msg.kind <= kind;
         can_msg.value <= value;
      end else begin
         can_valid <= 1'b0;
         can_msg.value <= ~can_msg.value;
      end
   end
endmodule

// ===== sim/tb_cluster_warning_and_gauge_ctrl.sv
`timescale 1ns/1ps
module tb_cluster_warning_and_gauge_ctrl;
   localparam int TK = 10;
   logic clk, arst_n, hsel, hwrite, hready, hreadyout, hresp, buzzer, lamp;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [31:0] haddr, hwdata, hrdata, rd;
   logic ign, dbk, pbk, occ, key, door, park, fluid, send, can_valid;
   logic [7:0] fuel, fuel_g, oil_g;
   logic [15:0] spd_g, rpm_g, ect_g, val;
   cwg_pkg::cwg_sig_t kind;
   cwg_pkg::cwg_can_t can_msg;
   int n_fail = 0;
   int samples_checked = 0;
   int spd, rpm, ect, oil, fv;
   assign hready = hreadyout;
   cwg_top #(.TICK_CYC(TK)) u_cwg_top (.CLK(clk), .ARST_N(arst_n), .HSEL(hsel),
      .HADDR(haddr), .HTRANS(htrans), .HWRITE(hwrite), .HSIZE(hsize), .HWDATA(hwdata),
      .HREADY(hready), .HRDATA(hrdata), .HREADYOUT(hreadyout), .HRESP(hresp),
      .IGNITION_RUN_SUPPLY(ign), .DRV_BUCKLE(dbk), .PASS_BUCKLE(pbk),
      .SEAT_OCCUPIED(occ), .KEY_INSERTED(key), .DRV_DOOR_OPEN(door), .PARK_BRAKE(park),
      .BRAKE_FLUID_LOW(fluid), .FUEL_SENDER(fuel), .CAN_VALID(can_valid),
      .CAN_MSG(can_msg), .BUZZER(buzzer), .BRAKE_LAMP(lamp), .SPEEDO(spd_g),
      .TACHO(rpm_g), .TEMP_GAUGE(ect_g), .FUEL_GAUGE(fuel_g), .OIL_GAUGE(oil_g));
   cwg_ecu_model u_cwg_ecu_model (.clk(clk), .arst_n(arst_n), .send(send), .kind(kind),
      .value(val), .can_valid(can_valid), .can_msg(can_msg));
   ////////////////////////////////////////////////////////////////
   initial begin
      clk = 1'b0;
      forever #2.5 clk = ~clk;
   end
   task automatic tally_and_finish();
      $display("checks %0d mismatches %0d", samples_checked, n_fail);
      if (n_fail == 0 && samples_checked > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
      samples_checked++;
      if (seen !== exp) begin
         n_fail++;
         $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
      end
   endtask
   task automatic cyc(input int n);
      repeat (n) @(posedge clk);
   endtask
   task automatic ahb(input logic wr, input logic [31:0] a, input logic [31:0] d);
      hsel <= 1'b1;
      haddr <= a;
      htrans <= 2'h2;
      hwrite <= wr;
      hsize <= 3'h2;
      do @(posedge clk); while (hreadyout !== 1'b1);
      htrans <= 2'h0;
      hsel <= 1'b0;
      hwdata <= d;
      do @(posedge clk); while (hreadyout !== 1'b1);
      rd = hrdata;
      chk(32'(hresp), 32'h0);
   endtask
   task automatic can(input cwg_pkg::cwg_sig_t k, input int v);
      kind <= k;
      val <= v[15:0];
      send <= 1'b1;
      cyc(1);
      send <= 1'b0;
      cyc(5);
   endtask
   ////////////////////////////////////////////////////////////////
   initial begin
      #(5 * 30000);
      n_fail++;
      tally_and_finish();
   end
   initial begin
      {hsel, hwrite, ign, dbk, pbk, occ, key, door, park, fluid, send} = '0;
      {htrans, hsize, haddr, hwdata, fuel, val} = '0;
      kind = cwg_pkg::SIG_SPEED;
      arst_n = 1'b0;
      void'($urandom(32'h5b85e1b5));
      dbk = 1'b1;
      pbk = 1'b1;
      repeat (10) @(posedge clk);
      arst_n <= 1'b1;
      cyc(2);
      ahb(1'b0, 32'h0000_0000, 32'h0);
      chk(rd, 32'h3);
      ahb(1'b0, 32'h0000_001c, 32'h0);
      chk(rd, 32'h0);
      // gauges from bus values, controller holds the last received values
      for (int i = 0; i < 3; i++) begin
         spd = $urandom_range(250, 0);
         rpm = $urandom_range(9000, 0);
         ect = $urandom_range(300, 0);
         can(cwg_pkg::SIG_SPEED, spd);
         can(cwg_pkg::SIG_RPM, rpm);
         can(cwg_pkg::SIG_ECT, ect);
         oil = 64 + (rpm >> 5) - (ect >> 2);
         oil = (oil < 0) ? 0 : (oil > 255) ? 255 : oil;
         chk(spd_g, spd);
         chk(rpm_g, rpm);
         chk(ect_g, ect);
         chk(oil_g, oil);
         ahb(1'b0, 32'h0000_0008, 32'h0);
         chk(rd, spd);
      end
      ahb(1'b1, 32'h0000_0000, 32'h1);
      cyc(3);
      chk(spd_g, 32'h0);
      chk(rpm_g, 32'h0);
      chk(ect_g, 32'h0);
      chk(oil_g, 32'h0);
      ahb(1'b1, 32'h0000_0000, 32'h3);
      can(cwg_pkg::SIG_SPEED, 0);
      fv = $urandom_range(255, 0);
      fuel <= fv[7:0];
      cyc(TK * 40);
      chk(fuel_g, fv);
      // ignition on with driver belt open: start alarm and bulb check
      dbk <= 1'b0;
      ign <= 1'b1;
      cyc(TK * 28);
      chk(lamp, 1'b1);
      chk(buzzer, 1'b1);
      ahb(1'b0, 32'h0000_0004, 32'h0);
      chk(rd, 32'h4f);
      cyc(TK * 4);
      chk(lamp, 1'b0);
      park <= 1'b1;
      cyc(3);
      chk(lamp, 1'b1);
      park <= 1'b0;
      fluid <= 1'b1;
      cyc(3);
      chk(lamp, 1'b1);
      fluid <= 1'b0;
      cyc(TK * 26);
      chk(buzzer, 1'b1);
      cyc(TK * 3);
      chk(buzzer, 1'b0);
      ign <= 1'b0;
      cyc(3);
      ign <= 1'b1;
      cyc(20);
      chk(buzzer, 1'b1);
      dbk <= 1'b1;
      cyc(3);
      chk(buzzer, 1'b0);
      // run alarm over passenger buckle and seat combinations
      can(cwg_pkg::SIG_SPEED, 25);
      for (int i = 0; i < 4; i++) begin
         pbk <= i[0];
         occ <= i[1];
         cyc(4);
         chk(buzzer, i == 2);
      end
      pbk <= 1'b1;
      dbk <= 1'b0;
      can(cwg_pkg::SIG_SPEED, 19);
      chk(buzzer, 1'b0);
      can(cwg_pkg::SIG_SPEED, 20);
      chk(buzzer, 1'b1);
      cyc(TK * 915);
      chk(buzzer, 1'b1);
      cyc(TK * 20);
      chk(buzzer, 1'b0);
      // key reminder over all switch combinations
      dbk <= 1'b1;
      can(cwg_pkg::SIG_SPEED, 0);
      for (int i = 0; i < 8; i++) begin
         ign <= i[2];
         key <= i[0];
         door <= i[1];
         cyc(4);
         chk(buzzer, i == 3);
      end
      ign <= 1'b0;
      key <= 1'b1;
      door <= 1'b1;
      cyc(4);
      chk(buzzer, 1'b1);
      ahb(1'b1, 32'h0000_0000, 32'h2);
      cyc(3);
      chk(buzzer, 1'b0);
      ahb(1'b1, 32'h0000_0000, 32'h3);
      cyc(3);
      chk(buzzer, 1'b1);
      tally_and_finish();
   end
endmodule
